// ---- verilog/gps_map.vh ----
/*
 * Register map, field layout and reset values of the shared GPIO port block.
 * Assumes an 8-bit register space with two banks selected by a separate bit.
 */
`ifndef GPS_MAP_VH
`define GPS_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define GPS_OFS_DATA0 8'h80
`define GPS_OFS_DATA1 8'h90
`define GPS_OFS_DATA2 8'ha0
`define GPS_OFS_DATA3 8'hb0
`define GPS_OFS_DATA4 8'hc0
`define GPS_OFS_DIR0  8'he1
`define GPS_OFS_DIR1  8'he2
`define GPS_OFS_DIR2  8'he3
`define GPS_OFS_DIR3  8'he4
`define GPS_OFS_DIR4  8'he5
`define GPS_OFS_PU0   8'he9
`define GPS_OFS_PU1   8'hea
`define GPS_OFS_PU2   8'heb
`define GPS_OFS_PU3   8'hec
`define GPS_OFS_PU4   8'hed

// ****************************************
// Register kinds and port numbers
// ****************************************
`define GPS_K_DATA 2'h0
`define GPS_K_DIR  2'h1
`define GPS_K_PU   2'h2
`define GPS_PORT5  3'h5

// ****************************************
// Implemented pins and reset values
// ****************************************
// Port 5 in bits 47:40 down to port 0 in bits 7:0
`define GPS_PIN_MASK 48'h071fff031fc8
`define GPS_RST_REG  48'h000000000000
`define GPS_RST_OEN  48'hffffffffffff

// ****************************************
// Shared pins of port 0
// ****************************************
`define GPS_BIT_PWM 3
`define GPS_BIT_I2  6
`define GPS_BIT_I3  7

`endif

// ---- verilog/gps_port.v ----
/*
 * Six-port bidirectional GPIO block with alternate-function pin sharing.
 * Assumes a simple register port (read data one cycle after the strobe),
 * pad inputs synchronous to mclk, and a pad that resolves pull-ups itself.
 */
// The implementer's own choice: the address-and-strobe port.
// Functional notes
// - Direction bit: zero input, one output
// - Pull-up bit acts only in input mode
// - Twenty-six implemented pins across six ports
// - Input pin reads return external pin level
// - Output read: RMW gets register, else pin
// - Port writes always update data register
// - Highest-priority enabled function takes pin
// - Lower function gets pin after higher disables
// - Only pin owner controls automatic pull-up
// - Owned pin: config writes stored, no effect
// - Owned pin: port writes leave pin unchanged
// - Port 0 pins shared with PWM, T4, IRQs
// - Bit 3: PWM first, timer second, port last
// - IRQ2 owns bit 6 when enabled and input
`timescale 1ns/1ps
`include "gps_map.vh"

module gps_port #(
  parameter PW = 8
) (
  input  wire          mclk,
  input  wire          rst,
  input  wire [7:0]    reg_addr,
  input  wire          reg_bank,
  input  wire [PW-1:0] reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  input  wire          reg_rmw,
  output reg  [PW-1:0] reg_rdata,
  input  wire [47:0]   pin_in,
  output reg  [47:0]   pin_out,
  output reg  [47:0]   pin_oe_n,
  output reg  [47:0]   pin_pullup,
  input  wire          pulse_width_output_zero_en,
  input  wire          pulse_width_output_zero_out,
  input  wire          t4_en,
  input  wire          t4_drive,
  input  wire          t4_out,
  input  wire          t4_pullup_req,
  input  wire          irq2_en,
  input  wire          irq3_en,
  output wire          irq2_pin,
  output wire          irq3_pin,
  output wire          t4_pin
);

  // ****************************************
  // Address decode
  // ****************************************
  // Result is {hit, kind[1:0], port[2:0]}
  function [5:0] gps_decode;
    input [7:0] a;
    input       b;
    begin
      case (a)
        `GPS_OFS_DATA0: gps_decode = {1'b1, `GPS_K_DATA, (b ? `GPS_PORT5 : 3'h0)};
        `GPS_OFS_DATA1: gps_decode = {~b, `GPS_K_DATA, 3'h1};
        `GPS_OFS_DATA2: gps_decode = {~b, `GPS_K_DATA, 3'h2};
        `GPS_OFS_DATA3: gps_decode = {~b, `GPS_K_DATA, 3'h3};
        `GPS_OFS_DATA4: gps_decode = {~b, `GPS_K_DATA, 3'h4};
        `GPS_OFS_DIR0:  gps_decode = {1'b1, `GPS_K_DIR, (b ? `GPS_PORT5 : 3'h0)};
        `GPS_OFS_DIR1:  gps_decode = {~b, `GPS_K_DIR, 3'h1};
        `GPS_OFS_DIR2:  gps_decode = {~b, `GPS_K_DIR, 3'h2};
        `GPS_OFS_DIR3:  gps_decode = {~b, `GPS_K_DIR, 3'h3};
        `GPS_OFS_DIR4:  gps_decode = {~b, `GPS_K_DIR, 3'h4};
        `GPS_OFS_PU0:   gps_decode = {1'b1, `GPS_K_PU, (b ? `GPS_PORT5 : 3'h0)};
        `GPS_OFS_PU1:   gps_decode = {~b, `GPS_K_PU, 3'h1};
        `GPS_OFS_PU2:   gps_decode = {~b, `GPS_K_PU, 3'h2};
        `GPS_OFS_PU3:   gps_decode = {~b, `GPS_K_PU, 3'h3};
        `GPS_OFS_PU4:   gps_decode = {~b, `GPS_K_PU, 3'h4};
        default:        gps_decode = 6'h00;
      endcase
    end
  endfunction

  wire [5:0]  wr_dec  = gps_decode(reg_addr, reg_bank);
  wire        wr_hit  = wr_dec[5];
  wire [1:0]  wr_kind = wr_dec[4:3];
  wire [5:0]  wr_idx  = {wr_dec[2:0], 3'h0};
  wire [47:0] mask    = `GPS_PIN_MASK;

  // ****************************************
  // Port registers
  // ****************************************
  reg [47:0] data;
  reg [47:0] dir;
  reg [47:0] pu;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      data <= `GPS_RST_REG;
      dir  <= `GPS_RST_REG;
      pu   <= `GPS_RST_REG;
    end else if (reg_wr && wr_hit) begin
      case (wr_kind)
        // Stored even when the pin is owned by another function
        `GPS_K_DATA: data[wr_idx +: 8] <= reg_wdata & mask[wr_idx +: 8];
        `GPS_K_DIR:  dir[wr_idx +: 8]  <= reg_wdata & mask[wr_idx +: 8];
        `GPS_K_PU:   pu[wr_idx +: 8]   <= reg_wdata & mask[wr_idx +: 8];
        default:     data <= data;
      endcase
    end
  end

  // ****************************************
  // Alternate-function arbitration
  // ****************************************
  // Frozen copy of the configuration seen before a function took the pin
  reg  [47:0] frz_dir;
  reg  [47:0] frz_pu;
  wire [47:0] owned;

  // Purely combinational priority, so release follows disable at once
  wire own_pwm = pulse_width_output_zero_en;
  wire own_t4  = t4_en & ~pulse_width_output_zero_en;
  wire own_i2  = irq2_en & ~frz_dir[`GPS_BIT_I2];
  wire own_i3  = irq3_en & ~frz_dir[`GPS_BIT_I3];

  // Timer input pull-up only counts when the timer really owns the pin
  wire t4_in_mode = own_t4 & ~t4_drive;
  wire drv_p3     = own_pwm | (own_t4 & t4_drive);
  wire val_p3     = own_pwm ? pulse_width_output_zero_out : t4_out;

  wire [47:0] alt_drv = {40'h0, 4'h0, drv_p3, 3'h0};
  wire [47:0] alt_val = {40'h0, 4'h0, val_p3, 3'h0};
  wire [47:0] alt_pu  = {40'h0,
                         frz_pu[`GPS_BIT_I3] & own_i3,
                         frz_pu[`GPS_BIT_I2] & own_i2,
                         2'h0,
                         t4_pullup_req & t4_in_mode,
                         3'h0};

  assign owned = {40'h0, own_i3, own_i2, 2'h0, own_pwm | own_t4, 3'h0};

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      frz_dir <= `GPS_RST_REG;
      frz_pu  <= `GPS_RST_REG;
    end else begin
      frz_dir <= (owned & frz_dir) | (~owned & dir);
      frz_pu  <= (owned & frz_pu) | (~owned & pu);
    end
  end

  // ****************************************
  // Pad drive
  // ****************************************
  wire [47:0] eff_out;
  wire [47:0] next_out;
  wire [47:0] next_oe_n;
  wire [47:0] next_pullup;

  genvar g;
  generate
    for (g = 0; g < 48; g = g + 1) begin : pad
      // Owned pins ignore the data and config registers
      assign eff_out[g]     = owned[g] ? alt_drv[g] : dir[g];
      assign next_out[g]    = owned[g] ? alt_val[g] : data[g];
      assign next_oe_n[g]   = ~(eff_out[g] & mask[g]);
      assign next_pullup[g] = mask[g] &
                              (owned[g] ? alt_pu[g] : (~dir[g] & pu[g]));
    end
  endgenerate

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_out    <= `GPS_RST_REG;
      pin_oe_n   <= `GPS_RST_OEN;
      pin_pullup <= `GPS_RST_REG;
    end else begin
      pin_out    <= next_out & mask;
      pin_oe_n   <= next_oe_n;
      pin_pullup <= next_pullup;
    end
  end

  // Peripherals see the pin only while they own it
  assign irq2_pin = own_i2 & pin_in[`GPS_BIT_I2];
  assign irq3_pin = own_i3 & pin_in[`GPS_BIT_I3];
  assign t4_pin   = t4_in_mode & pin_in[`GPS_BIT_PWM];

  // ****************************************
  // Read path
  // ****************************************
  reg  [PW-1:0] rd_value;
  wire [47:0]   rd_pins = (eff_out & {48{reg_rmw}} & data) |
                          (~(eff_out & {48{reg_rmw}}) & pin_in);

  always @* begin
    case (wr_kind)
      `GPS_K_DATA: rd_value = rd_pins[wr_idx +: 8] & mask[wr_idx +: 8];
      `GPS_K_DIR:  rd_value = dir[wr_idx +: 8];
      `GPS_K_PU:   rd_value = pu[wr_idx +: 8];
      default:     rd_value = {PW{1'b0}};
    endcase
  end

  // Data stand only in the cycle after the strobe
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= {PW{1'b0}};
    end else if (reg_rd && wr_hit) begin
      reg_rdata <= rd_value;
    end else begin
      reg_rdata <= {PW{1'b0}};
    end
  end

endmodule

// ---- test/gps_port_asserts.sv ----
/* Checker for gps_port, bound to its top ports.
   Assumes the map header is on the include path. */
`timescale 1ns/1ps
`include "gps_map.vh"
module gps_port_asserts (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        reg_rd,
  input wire logic        reg_rmw,
  input wire logic        reg_bank,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_rdata,
  input wire logic [47:0] pin_in,
  input wire logic [47:0] pin_out,
  input wire logic [47:0] pin_oe_n,
  input wire logic [47:0] pin_pullup,
  input wire logic        pulse_width_output_zero_en,
  input wire logic        pulse_width_output_zero_out,
  input wire logic        t4_en,
  input wire logic        t4_drive,
  input wire logic        t4_out,
  input wire logic        t4_pullup_req
);
  // ****
  // Properties
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_rd_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  chk_pad_read_lat: assert property (reg_rd && !reg_rmw && !reg_bank && reg_addr == 8'hb0
    |=> reg_rdata == $past(pin_in[31:24])) else $error("pad read wrong");
  chk_unimpl_drive: assert property ((pin_oe_n | `GPS_PIN_MASK) == 48'hffffffffffff)
    else $error("unused pin driven");
  chk_unimpl_pull: assert property ((pin_pullup & ~`GPS_PIN_MASK) == 48'h0)
    else $error("unused pin pulled");
  chk_pull_input_only: assert property ((pin_pullup & ~pin_oe_n) == 48'h0)
    else $error("pull-up on driven pin");
  chk_pwm_owns_pin: assert property (pulse_width_output_zero_en |=> !pin_oe_n[3] && !pin_pullup[3]
    && pin_out[3] == $past(pulse_width_output_zero_out)) else $error("pwm not on pin");
  chk_t4_drive_second: assert property (!pulse_width_output_zero_en && t4_en && t4_drive |=> !pin_oe_n[3]
    && pin_out[3] == $past(t4_out)) else $error("timer drive lost");
  chk_t4_auto_pull: assert property (!pulse_width_output_zero_en && t4_en && !t4_drive |=> pin_oe_n[3]
    && pin_pullup[3] == $past(t4_pullup_req)) else $error("timer pull-up wrong");
  cover property (pulse_width_output_zero_en ##1 !pulse_width_output_zero_en && t4_en);
  cover property (reg_rd && reg_rmw);
  cover property (t4_en && t4_drive);
endmodule
bind gps_port gps_port_asserts u_chk (.*);

// ---- test/gps_pad_model.sv ----
/* Pads and board around gps_port.
   Assumes the bench drives ext_en and ext_val. */
`timescale 1ns/1ps
module gps_pad_model (
  input  wire logic        mclk,
  input  wire logic [47:0] pin_out,
  input  wire logic [47:0] pin_oe_n,
  input  wire logic [47:0] pin_pullup,
  input  wire logic [47:0] ext_en,
  input  wire logic [47:0] ext_val,
  output wire logic [47:0] pin_in
);
  logic [47:0] prev = 48'h0;
  // Board driver wins, so a short against an output can be staged
  // Undriven without pull-up drifts to the inverse of its last level
  assign pin_in = (ext_en & ext_val) | (~ext_en & ~pin_oe_n & pin_out)
                | (~ext_en & pin_oe_n & (pin_pullup | ~prev));
  always @(posedge mclk) prev <= pin_in;
endmodule

// ---- test/test_gps_port_with_pin_sharing.sv ----
/* Register and pin-sharing tests of gps_port.
   Assumes gps_pad_model stands on the pads. */
`timescale 1ns/1ps
`include "gps_map.vh"
module test_gps_port_with_pin_sharing;
  logic mclk = 0, rst = 1, reg_bank = 0, reg_wr = 0, reg_rd = 0, reg_rmw = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic pulse_width_output_zero_en = 0, pulse_width_output_zero_out = 0, t4_en = 0, t4_drive = 0, t4_out = 0, t4_pullup_req = 0;
  logic irq2_en = 0, irq3_en = 0, irq2_pin, irq3_pin, t4_pin;
  logic [47:0] ext_en = '1, ext_val = '0, pin_in, pin_out, pin_oe_n, pin_pullup;
  logic [7:0] msk [6] = '{8'hc8, 8'h1f, 8'h03, 8'hff, 8'h1f, 8'h07};
  int error_cnt = 0, tests_run = 0;
  always #5 mclk = ~mclk;
  gps_port u_dut (.*);
  gps_pad_model u_pad (.*);
  function automatic [7:0] ad(int k, int p);
    ad = k == 0 ? 8'h80 + 8'h10 * (p % 5) : (k == 1 ? 8'he1 : 8'he9) + p % 5;
  endfunction
  task automatic cmp(input [47:0] g, e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input [7:0] a, input b, input [7:0] d);
    @(posedge mclk); reg_addr <= a; reg_bank <= b; reg_wdata <= d; reg_wr <= 1;
    @(posedge mclk); reg_wr <= 0;
  endtask
  task automatic rd(input [7:0] a, input b, m, input [7:0] e);
    @(posedge mclk); reg_addr <= a; reg_bank <= b; reg_rmw <= m; reg_rd <= 1;
    @(posedge mclk); reg_rd <= 0; #1; cmp(reg_rdata, e);
  endtask
  task automatic wt;
    repeat (2) @(posedge mclk); #1;
  endtask
  task results;
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #20000; error_cnt++; results;
  end
  initial begin
    repeat (12) @(posedge mclk); rst <= 0;
    for (int p = 0; p < 6; p++) for (int j = 1; j < 4; j++) begin
      rd(ad(j % 3, p), p == 5, 0, 8'h00);
      wr(ad(j % 3, p), p == 5, 8'hff);
      rd(ad(j % 3, p), p == 5, 1, msk[p]);
    end
    wt; cmp(pin_oe_n, ~`GPS_PIN_MASK);
    cmp(pin_pullup, 48'h0);
    cmp(pin_out, `GPS_PIN_MASK);
    wr(8'h81, 0, 8'hff); rd(8'h81, 0, 0, 8'h00); rd(8'he2, 1, 0, 8'h00);
    @(posedge mclk); ext_val <= 48'h0a00;
    rd(8'h90, 0, 0, 8'h0a); rd(8'h90, 0, 1, 8'h1f);
    for (int p = 0; p < 6; p++) wr(ad(1, p), p == 5, 8'h00);
    @(posedge mclk); ext_en <= '0;
    wt; cmp(pin_pullup, `GPS_PIN_MASK);
    rd(8'hb0, 0, 0, 8'hff);
    wr(8'he1, 0, 8'h08); wr(8'h80, 0, 8'h00);
    @(posedge mclk); pulse_width_output_zero_en <= 1; pulse_width_output_zero_out <= 1;
    wt; cmp({pin_oe_n[3], pin_out[3], pin_pullup[3]}, 3'b010);
    @(posedge mclk); pulse_width_output_zero_out <= 0;
    wr(8'he1, 0, 8'h00); wr(8'h80, 0, 8'h08);
    wt; cmp({pin_oe_n[3], pin_out[3], pin_pullup[3]}, 3'b000);
    rd(8'h80, 0, 1, 8'hc8);
    @(posedge mclk); t4_en <= 1; t4_pullup_req <= 1;
    wt; cmp({pin_oe_n[3], pin_pullup[3]}, 2'b00);
    @(posedge mclk); pulse_width_output_zero_en <= 0;
    wt; cmp({pin_oe_n[3], pin_pullup[3], t4_pin}, 3'b111);
    @(posedge mclk); t4_drive <= 1; t4_out <= 1;
    wt; cmp({pin_oe_n[3], pin_out[3]}, 2'b01);
    @(posedge mclk); t4_en <= 0;
    wt; cmp({pin_oe_n[3], pin_pullup[3]}, 2'b11);
    @(posedge mclk); irq2_en <= 1; irq3_en <= 1; ext_en <= 48'hc0; ext_val <= 48'h40;
    wt; cmp({irq3_pin, irq2_pin}, 2'b01);
    @(posedge mclk); irq2_en <= 0;
    wt; cmp(irq2_pin, 1'b0);
    wr(8'he1, 0, 8'hc0);
    @(posedge mclk); irq2_en <= 1;
    wt; cmp({pin_oe_n[7], pin_oe_n[6], irq2_pin}, 3'b100);
    rd(8'he1, 0, 0, 8'hc0);
    results;
  end
endmodule
